// [rtl/dac_door_ctrl.sv]
// Purpose: Single-door access controller with card programming modes.
// Assumes: Card reader and schedule logic share sys_clk; APB slave.
// Notes:   The lock pin is open collector; the enable pulls it to 0 V.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
// Operation
// - Release time 0..255 s, default 7.
// - Lock polarity direct or inverted, default direct.
// - Timed or toggle lock, default timed.
// - Permanent release off or schedule index.
// - Timed: lock and beeper for duration.
// - Toggle: invert lock, beep for duration.
// - Door open by stored card or host.
// - Programming card ignored during release.
// - Valid card restarts timed release.
// - Permanent release while schedule is valid.
// - Permanent release and toggle exclusive.
// - Online: report each valid card.
// - Same in both modes; events logged.
// - Programming cards enter insert or delete.
// - No programming during address setting.
// - Programmed cards carry no schedule.
// - Store or remove cards; 15 s timeout.
// - Five insert-card reads enter neighbour delete.
// - Reference card, then delete its neighbour.
// - Five delete-card reads erase all cards.
// - New card after last inserted one.
// - Identifier length 24, 32 or 40 bits.
// - Memory holds 748 user cards.
// - Lock pin open collector, 0 V active.
// - Yellow steady in insert or delete, fast flash in neighbour delete, slow flash while released.
module dac_door_ctrl
	import dac_pkg::*;
#(
	parameter int TICK_CYC  = TICK_CYCLES,
	parameter int FLASH_CYC = FLASH_HALF_CYCLES,
	parameter int DEPTH     = CARD_DEPTH
) (
	// Clock and reset.
	input  wire logic               sys_clk,
	input  wire logic               rst,
	// APB slave.
	input  wire logic [11:0]        paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Card reader front end.
	input  wire logic               cardValid,
	input  wire logic [ID_W-1:0]    cardId,
	// Schedule evaluation and address mode.
	input  wire logic [SCHED_N-1:0] scheduleValid,
	input  wire logic               addrSetMode,
	// Door and indicators.
	output logic                    lockPinOut,
	output logic                    lockPinOe,
	output logic                    beeper,
	output logic                    yellowLed
);

	localparam int IDXW = $clog2(DEPTH + 1);
	localparam int TW   = $clog2(TICK_CYC + 1);
	localparam int FW   = $clog2(FLASH_CYC + 1);

	logic [31:0] prdataReg, prdataNext;
	logic        preadyReg, preadyNext, pslverrReg, pslverrNext;
	logic [7:0]  relTimeReg, relTimeNext;
	logic        polInvReg, polInvNext, togModeReg, togModeNext;
	logic        permEnReg, permEnNext, beepEnReg, beepEnNext;
	logic        onlineReg, onlineNext;
	logic [SCHED_W-1:0] schedReg, schedNext;
	dac_idlen_t  idLenReg, idLenNext;
	logic [ID_W-1:0] pInsReg, pInsNext, pDelReg, pDelNext;
	logic [ID_W-1:0] lastIdReg, lastIdNext;
	logic        rptReg, rptNext;
	logic [15:0] evtReg, evtNext;
	logic [TW-1:0] tickCntReg, tickCntNext;
	logic [FW-1:0] flCntReg, flCntNext;
	logic        slowReg, slowNext, fastReg, fastNext;
	logic [7:0]  relCntReg, relCntNext;
	logic        togStReg, togStNext;
	logic        lockOeReg, lockOeNext, beepReg, beepNext, ylwReg, ylwNext;
	dac_prog_t   stateReg, stateNext;
	logic [2:0]  repReg, repNext;
	logic [3:0]  idleReg, idleNext;
	logic [IDXW-1:0] refReg, refNext;
	logic        access, wr, hostRel, tick, releasing, permActive, released;
	logic [ID_W-1:0] cardM;
	logic        isIns, isDel, isUser, hit, doorEvt, progMode;
	logic        insEn, delEn, clrEn;
	logic [IDXW-1:0] hitIdx, delIdx, insPtr;

	// keep only the selected number of low identifier bits.
	function automatic logic [ID_W-1:0] maskId(logic [ID_W-1:0] id,
		dac_idlen_t len);
		logic [ID_W-1:0] m;
		m = id;
		if (len == ID_LEN_24) begin
			m[ID_W-1:24] = '0;
		end else if (len == ID_LEN_32) begin
			m[ID_W-1:32] = '0;
		end
		return m;
	endfunction

	// Card classification against the two programming cards.
	assign cardM     = maskId(cardId, idLenReg);
	assign isIns     = cardValid && cardM == maskId(pInsReg, idLenReg);
	assign isDel     = cardValid && cardM == maskId(pDelReg, idLenReg) &&
		!isIns;
	assign isUser    = cardValid && !isIns && !isDel;
	assign progMode  = (stateReg != ST_NORMAL);
	assign releasing = (relCntReg != 8'h00);
	assign access    = psel && penable;
	assign wr        = access && pwrite && preadyReg;
	// a stored card in normal operation or a host request opens.
	assign hostRel   = wr && paddr == OFF_CMD && pwdata[CMD_REL_BIT];
	// a stored card is valid with no schedule check.
	assign doorEvt   = (!progMode && isUser && hit) || hostRel;
	// permanent release only outside toggle mode.
	assign permActive = permEnReg && !togModeReg && scheduleValid[schedReg];
	assign released  = togModeReg ? togStReg : (releasing || permActive);

	dac_card_store #(.DEPTH(DEPTH), .IDW(ID_W), .IDXW(IDXW)) u_store (
		.clk     (sys_clk),
		.rst     (rst),
		.lookupId(cardM),
		.hit     (hit),
		.hitIdx  (hitIdx),
		.insEn   (insEn),
		.insId   (cardM),
		.delEn   (delEn),
		.delIdx  (delIdx),
		.clrEn   (clrEn),
		.insPtr  (insPtr)
	);

	// APB slave: one wait state, then the answer with pready.
	always_comb begin
		preadyNext  = access && !preadyReg;
		pslverrNext = 1'b0;
		prdataNext  = 32'h0000_0000;
		relTimeNext = relTimeReg;
		polInvNext  = polInvReg;
		togModeNext = togModeReg;
		permEnNext  = permEnReg;
		schedNext   = schedReg;
		beepEnNext  = beepEnReg;
		idLenNext   = idLenReg;
		onlineNext  = onlineReg;
		pInsNext    = pInsReg;
		pDelNext    = pDelReg;
		if (access && !preadyReg) begin
			unique case (paddr)
				OFF_CTRL: prdataNext = {11'h000, onlineReg, idLenReg,
					beepEnReg, schedReg, permEnReg, togModeReg, polInvReg,
					relTimeReg};
				OFF_CMD: prdataNext = 32'h0000_0000;
				OFF_STATUS: begin
					prdataNext[ST_LOCK_BIT] = released;
					prdataNext[ST_REL_BIT]  = releasing;
					prdataNext[ST_BEEP_BIT] = beepReg;
					prdataNext[ST_PROG_BIT] = progMode;
					prdataNext[ST_RPT_BIT]  = rptReg;
					prdataNext[ST_STATE_LSB +: 5] = stateReg;
					prdataNext[ST_PTR_LSB +: IDXW] = insPtr;
				end
				OFF_LAST_LO: prdataNext = lastIdReg[31:0];
				OFF_LAST_HI: prdataNext = {24'h00_0000, lastIdReg[39:32]};
				OFF_PINS_LO: prdataNext = pInsReg[31:0];
				OFF_PINS_HI: prdataNext = {24'h00_0000, pInsReg[39:32]};
				OFF_PDEL_LO: prdataNext = pDelReg[31:0];
				OFF_PDEL_HI: prdataNext = {24'h00_0000, pDelReg[39:32]};
				OFF_EVENTS: prdataNext = {16'h0000, evtReg};
				default: pslverrNext = 1'b1;
			endcase
		end
		if (wr) begin
			unique case (paddr)
				OFF_CTRL: begin
					relTimeNext = pwdata[CTRL_TIME_LSB +: 8];
					polInvNext  = pwdata[CTRL_POL_BIT];
					togModeNext = pwdata[CTRL_TOG_BIT];
					permEnNext  = pwdata[CTRL_PERM_BIT];
					schedNext   = pwdata[CTRL_SCHED_LSB +: SCHED_W];
					beepEnNext  = pwdata[CTRL_BEEP_BIT];
					if (pwdata[CTRL_IDLEN_LSB +: 2] != 2'h3) begin
						idLenNext = dac_idlen_t'(pwdata[CTRL_IDLEN_LSB +: 2]);
					end
					onlineNext  = pwdata[CTRL_ONLINE_BIT];
				end
				OFF_PINS_LO: pInsNext[31:0]  = pwdata;
				OFF_PINS_HI: pInsNext[39:32] = pwdata[7:0];
				OFF_PDEL_LO: pDelNext[31:0]  = pwdata;
				OFF_PDEL_HI: pDelNext[39:32] = pwdata[7:0];
				default: pslverrNext = 1'b0;
			endcase
		end
	end

	// APB and configuration registers.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prdataReg  <= 32'h0000_0000;
			preadyReg  <= 1'b0;
			pslverrReg <= 1'b0;
			relTimeReg <= REL_TIME_RST;
			polInvReg  <= POL_RST;
			togModeReg <= TOG_RST;
			permEnReg  <= PERM_RST;
			schedReg   <= '0;
			beepEnReg  <= BEEP_RST;
			idLenReg   <= ID_LEN_40;
			onlineReg  <= ONLINE_RST;
			pInsReg    <= '0;
			pDelReg    <= '0;
		end else begin
			prdataReg  <= prdataNext;
			preadyReg  <= preadyNext;
			pslverrReg <= pslverrNext;
			relTimeReg <= relTimeNext;
			polInvReg  <= polInvNext;
			togModeReg <= togModeNext;
			permEnReg  <= permEnNext;
			schedReg   <= schedNext;
			beepEnReg  <= beepEnNext;
			idLenReg   <= idLenNext;
			onlineReg  <= onlineNext;
			pInsReg    <= pInsNext;
			pDelReg    <= pDelNext;
		end
	end

	// one-second prescaler, restarted by any card or door event.
	always_comb begin
		tick        = (tickCntReg == TW'(TICK_CYC - 1));
		tickCntNext = tick ? '0 : tickCntReg + 1'b1;
		if (doorEvt || cardValid) begin
			tickCntNext = '0;
		end
		flCntNext = (flCntReg == FW'(FLASH_CYC - 1)) ? '0 : flCntReg + 1'b1;
		slowNext  = slowReg ^ (flCntReg == FW'(FLASH_CYC - 1));
		fastNext  = fastReg ^ ((flCntReg == FW'(FLASH_CYC - 1)) ||
			(flCntReg == FW'(FLASH_CYC / 2 - 1)));
	end

	// Prescaler and flasher registers.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tickCntReg <= '0;
			flCntReg   <= '0;
			slowReg    <= 1'b0;
			fastReg    <= 1'b0;
		end else begin
			tickCntReg <= tickCntNext;
			flCntReg   <= flCntNext;
			slowReg    <= slowNext;
			fastReg    <= fastNext;
		end
	end

	// Door release, lock pin, beeper, indicator, report and event log.
	always_comb begin
		relCntNext = relCntReg;
		togStNext  = togStReg;
		// load full duration, zero gives none.
		if (doorEvt) begin
			relCntNext = relTimeReg;
			togStNext  = togModeReg ? !togStReg : togStReg;
		end else if (tick && releasing) begin
			relCntNext = relCntReg - 8'h01;
		end
		// enable pulls the pin to 0 V when active.
		lockOeNext = released ^ polInvReg;
		beepNext   = releasing && beepEnReg;
		// steady in insert or delete, fast flash in neighbour delete, slow flash while released.
		if (stateReg == ST_INSERT || stateReg == ST_DELETE) begin
			ylwNext = 1'b1;
		end else if (progMode) begin
			ylwNext = fastReg;
		end else begin
			ylwNext = released && slowReg;
		end
		// online valid reads latch a report; the report set wins.
		lastIdNext = lastIdReg;
		rptNext    = rptReg;
		if (wr && paddr == OFF_CMD && pwdata[CMD_ACK_BIT]) begin
			rptNext = 1'b0;
		end
		if (!progMode && isUser && hit && onlineReg) begin
			rptNext    = 1'b1;
			lastIdNext = cardM;
		end
		// door events are counted in both modes.
		evtNext = doorEvt ? evtReg + 16'h0001 : evtReg;
	end

	// Door and indicator registers.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			relCntReg <= 8'h00;
			togStReg  <= 1'b0;
			lockOeReg <= 1'b0;
			beepReg   <= 1'b0;
			ylwReg    <= 1'b0;
			lastIdReg <= '0;
			rptReg    <= 1'b0;
			evtReg    <= 16'h0000;
		end else begin
			relCntReg <= relCntNext;
			togStReg  <= togStNext;
			lockOeReg <= lockOeNext;
			beepReg   <= beepNext;
			ylwReg    <= ylwNext;
			lastIdReg <= lastIdNext;
			rptReg    <= rptNext;
			evtReg    <= evtNext;
		end
	end

	// Programming state machine driving the card memory.
	always_comb begin
		stateNext = stateReg;
		repNext   = repReg;
		idleNext  = idleReg;
		refNext   = refReg;
		insEn     = 1'b0;
		delEn     = 1'b0;
		delIdx    = hitIdx;
		clrEn     = 1'b0;
		if (cardValid) begin
			idleNext = 4'h0;
		end else if (tick && progMode) begin
			idleNext = idleReg + 4'h1;
		end
		unique case (stateReg)
			ST_NORMAL: begin
				// enter only when idle and not addressing.
				if ((isIns || isDel) && !releasing && !addrSetMode) begin
					stateNext = isIns ? ST_INSERT : ST_DELETE;
					repNext   = 3'h0;
				end
			end
			ST_INSERT: begin
				// store cards; five insert-card reads switch.
				repNext = isIns ? repReg + 3'h1 : (cardValid ? 3'h0 : repReg);
				if (isIns && repReg + 3'h1 == PROG_REPEAT) begin
					stateNext = ST_NBR_REF;
				end
				insEn = isUser && !hit;
			end
			ST_DELETE: begin
				// remove cards; five delete-card reads erase.
				repNext = isDel ? repReg + 3'h1 : (cardValid ? 3'h0 : repReg);
				if (isDel && repReg + 3'h1 == PROG_REPEAT) begin
					clrEn     = 1'b1;
					stateNext = ST_NORMAL;
				end
				delEn = isUser && hit;
			end
			ST_NBR_REF: begin
				// a stored reference card is taken first.
				if (isUser && hit) begin
					refNext   = hitIdx;
					stateNext = ST_NBR_DIR;
				end
			end
			ST_NBR_DIR: begin
				// delete card removes before, insert card after.
				delIdx = isDel ? refReg - 1'b1 : refReg + 1'b1;
				delEn  = (isDel && refReg != '0) ||
					(isIns && refReg != IDXW'(DEPTH - 1));
				if (isDel || isIns) begin
					stateNext = ST_NORMAL;
				end
			end
			default: stateNext = ST_NORMAL;
		endcase
		// leave programming after the inactivity timeout.
		if (progMode && !cardValid && tick &&
			idleReg == 4'(PROG_TIMEOUT_S - 1)) begin
			stateNext = ST_NORMAL;
		end
	end

	// Programming state registers.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stateReg <= ST_NORMAL;
			repReg   <= 3'h0;
			idleReg  <= 4'h0;
			refReg   <= '0;
		end else begin
			stateReg <= stateNext;
			repReg   <= repNext;
			idleReg  <= idleNext;
			refReg   <= refNext;
		end
	end

	// Output drive from flip-flops; lockPinOut tied to 0.
	assign prdata     = prdataReg;
	assign pready     = preadyReg;
	assign pslverr    = pslverrReg;
	assign lockPinOut = 1'b0;
	assign lockPinOe  = lockOeReg;
	assign beeper     = beepReg;
	assign yellowLed  = ylwReg;

	// Checks on the release, lock, programming and APB behaviour.
	a_rel_load: assert property (@(posedge sys_clk) disable iff (rst)
		doorEvt |=> relCntReg == $past(relTimeReg))
		else $error("release count not loaded with full duration");
	a_zero_time: assert property (@(posedge sys_clk) disable iff (rst)
		doorEvt && relTimeReg == 8'h00 |=> !releasing ##1 !beepReg)
		else $error("zero duration produced a release");
	a_tog_flip: assert property (@(posedge sys_clk) disable iff (rst)
		doorEvt && togModeReg |=> togStReg != $past(togStReg))
		else $error("toggle mode did not invert the lock state");
	a_prog_block: assert property (@(posedge sys_clk) disable iff (rst)
		!progMode && (releasing || addrSetMode) |=> !progMode)
		else $error("programming entered during release or addressing");
	a_perm_hold: assert property (@(posedge sys_clk) disable iff (rst)
		permActive |=> lockPinOe == !$past(polInvReg))
		else $error("permanent release not held on the lock pin");
	a_excl_perm: assert property (@(posedge sys_clk) disable iff (rst)
		togModeReg && !togStReg && !polInvReg |=> !lockPinOe)
		else $error("permanent release active in toggle mode");
	a_beep_gate: assert property (@(posedge sys_clk) disable iff (rst)
		beeper |-> $past(beepEnReg) && $past(releasing))
		else $error("beeper without enabled release");
	a_prog_tmo: assert property (@(posedge sys_clk) disable iff (rst)
		progMode && tick && !cardValid && idleReg == 4'(PROG_TIMEOUT_S - 1)
		|=> stateReg == ST_NORMAL)
		else $error("programming timeout not taken");
	a_apb_wait: assert property (@(posedge sys_clk) disable iff (rst)
		psel && !penable ##1 psel && penable |-> !pready ##1 pready)
		else $error("APB answer not one wait state");

endmodule // dac_door_ctrl

// [shared/dac_pkg.sv]
// Purpose: Shared constants and types of the door access controller.
// Assumes: One 20 MHz system clock; APB register window of 32-bit words.
// Notes:   Offsets are byte addresses on the APB bus.
package dac_pkg;

	// Clock rate and derived timing counts.
	localparam int CLK_FREQ_HZ       = 20_000_000;
	localparam int TICK_PERIOD_S     = 1;
	localparam int TICK_CYCLES       = CLK_FREQ_HZ * TICK_PERIOD_S;
	localparam int FLASH_HALF_MS     = 250;
	localparam int FLASH_HALF_CYCLES = CLK_FREQ_HZ / 1000 * FLASH_HALF_MS;
	localparam int PROG_TIMEOUT_S    = 15;

	// Sizes of the card memory and the schedule set.
	localparam int CARD_DEPTH = 748;
	localparam int ID_W       = 40;
	localparam int SCHED_N    = 64;
	localparam int SCHED_W    = 6;

	// Repeated programming card reads that trigger a special function.
	localparam logic [2:0] PROG_REPEAT = 3'h5;

	// Identifier length choices.
	typedef enum logic [1:0] {
		ID_LEN_24 = 2'h0,
		ID_LEN_32 = 2'h1,
		ID_LEN_40 = 2'h2
	} dac_idlen_t;

	// Programming state machine, one-hot.
	typedef enum logic [4:0] {
		ST_NORMAL  = 5'h01,
		ST_INSERT  = 5'h02,
		ST_DELETE  = 5'h04,
		ST_NBR_REF = 5'h08,
		ST_NBR_DIR = 5'h10
	} dac_prog_t;

	// Register offsets.
	localparam logic [11:0] OFF_CTRL    = 12'h000;
	localparam logic [11:0] OFF_CMD     = 12'h004;
	localparam logic [11:0] OFF_STATUS  = 12'h008;
	localparam logic [11:0] OFF_LAST_LO = 12'h00c;
	localparam logic [11:0] OFF_LAST_HI = 12'h010;
	localparam logic [11:0] OFF_PINS_LO = 12'h014;
	localparam logic [11:0] OFF_PINS_HI = 12'h018;
	localparam logic [11:0] OFF_PDEL_LO = 12'h01c;
	localparam logic [11:0] OFF_PDEL_HI = 12'h020;
	localparam logic [11:0] OFF_EVENTS  = 12'h024;

	// Control register fields and their reset values.
	localparam int CTRL_TIME_LSB   = 0;
	localparam int CTRL_POL_BIT    = 8;
	localparam int CTRL_TOG_BIT    = 9;
	localparam int CTRL_PERM_BIT   = 10;
	localparam int CTRL_SCHED_LSB  = 11;
	localparam int CTRL_BEEP_BIT   = 17;
	localparam int CTRL_IDLEN_LSB  = 18;
	localparam int CTRL_ONLINE_BIT = 20;
	localparam logic [7:0] REL_TIME_RST = 8'h07;
	localparam logic       POL_RST      = 1'h0;
	localparam logic       TOG_RST      = 1'h0;
	localparam logic       PERM_RST     = 1'h0;
	localparam logic       BEEP_RST     = 1'h1;
	localparam logic       ONLINE_RST   = 1'h0;

	// Command and status fields.
	localparam int CMD_REL_BIT  = 0;
	localparam int CMD_ACK_BIT  = 1;
	localparam int ST_LOCK_BIT  = 0;
	localparam int ST_REL_BIT   = 1;
	localparam int ST_BEEP_BIT  = 2;
	localparam int ST_PROG_BIT  = 3;
	localparam int ST_RPT_BIT   = 4;
	localparam int ST_STATE_LSB = 5;
	localparam int ST_PTR_LSB   = 16;

endpackage

// [rtl/dac_card_store.sv]
// Purpose: Flip-flop card memory with lookup, ordered insert and delete.
// Assumes: At most one of insert, delete or clear per cycle.
// Notes:   Lookup is combinational over all entries; lowest index wins.
`timescale 1ns/1ps
module dac_card_store
	import dac_pkg::*;
#(
	parameter int DEPTH = CARD_DEPTH,
	parameter int IDW   = ID_W,
	parameter int IDXW  = $clog2(DEPTH + 1)
) (
	// Clock and reset.
	input  wire logic            clk,
	input  wire logic            rst,
	// Lookup.
	input  wire logic [IDW-1:0]  lookupId,
	output logic                 hit,
	output logic [IDXW-1:0]      hitIdx,
	// Updates.
	input  wire logic            insEn,
	input  wire logic [IDW-1:0]  insId,
	input  wire logic            delEn,
	input  wire logic [IDXW-1:0] delIdx,
	input  wire logic            clrEn,
	output logic [IDXW-1:0]      insPtr
);

	logic [IDXW-1:0] ptrReg;
	logic [IDXW-1:0] ptrNext;
	logic [DEPTH-1:0] match;
	logic            full;

	assign full   = (ptrReg == IDXW'(DEPTH));
	assign insPtr = ptrReg;

	// One storage cell per card position.
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		logic           validReg;
		logic           validNext;
		logic [IDW-1:0] idReg;
		logic [IDW-1:0] idNext;

		// new cards go after the last inserted.
		always_comb begin
			validNext = validReg;
			idNext    = idReg;
			if (clrEn) begin
				validNext = 1'b0;
			end else if (insEn && !full && ptrReg == IDXW'(i)) begin
				validNext = 1'b1;
				idNext    = insId;
			end else if (delEn && delIdx == IDXW'(i)) begin
				validNext = 1'b0;
			end
		end

		// Entry registers.
		always_ff @(posedge clk) begin
			if (rst) begin
				validReg <= 1'b0;
				idReg    <= '0;
			end else begin
				validReg <= validNext;
				idReg    <= idNext;
			end
		end

		assign match[i] = validReg && (idReg == lookupId);
	end

	// Priority encoder, the lowest matching position wins.
	always_comb begin
		hit    = 1'b0;
		hitIdx = '0;
		for (int k = DEPTH - 1; k >= 0; k--) begin
			if (match[k]) begin
				hit    = 1'b1;
				hitIdx = IDXW'(k);
			end
		end
	end

	// pointer stops at the memory size.
	always_comb begin
		ptrNext = ptrReg;
		if (clrEn) begin
			ptrNext = '0;
		end else if (insEn && !full) begin
			ptrNext = ptrReg + 1'b1;
		end
	end

	// Insert pointer register.
	always_ff @(posedge clk) begin
		if (rst) begin
			ptrReg <= '0;
		end else begin
			ptrReg <= ptrNext;
		end
	end

endmodule // dac_card_store

// [verif/dac_reader_model.sv]
// Purpose: Card reader front end model for the door controller bench.
// Assumes: The reader runs on sys_clk and sends one id per pulse.
// Notes:   Between reads the id lines carry the inverse of the last id.
`timescale 1ns/1ps
module dac_reader_model
	import dac_pkg::*;
(
	// Clock.
	input  wire logic            sys_clk,
	// Read requests from the bench.
	input  wire logic            go,
	input  wire logic [ID_W-1:0] goId,
	// Reader outputs.
	output logic                 cardValid,
	output logic [ID_W-1:0]      cardId
);
	// One pulse per read; stale ids are scrambled so they never match.
	always_ff @(posedge sys_clk) begin
		cardValid <= go;
		cardId    <= go ? goId : ~goId;
	end
endmodule // dac_reader_model

// [verif/dac_door_ctrl_bench.sv]
// Purpose: Self-checking bench for the door access controller.
// Assumes: Short tick of 20 cycles stands in for one second.
// Notes:   Cards are sent through the reader model; APB reads check state.
`timescale 1ns/1ps
module dac_door_ctrl_bench
	import dac_pkg::*;
;
	localparam int TK = 20;
	localparam logic [39:0] IC = 40'h0a00000001, DC = 40'h0b00000002;
	localparam logic [39:0] CA = 40'ha5, CB = 40'hb6, CC = 40'hc7;
	logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic go = 0, addrSetMode = 0, pready, pslverr, cardValid, err;
	logic lockPinOut, lockPinOe, beeper, yellowLed;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [ID_W-1:0] cardId, goId = '0;
	logic [SCHED_N-1:0] scheduleValid = '0;
	int fail_count = 0, n_compared = 0;

	// Clock at 20 MHz.
	always #25 sys_clk = ~sys_clk;

	dac_door_ctrl #(.TICK_CYC(TK), .FLASH_CYC(8), .DEPTH(8)) dac_door_ctrl_i (
		.sys_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .cardValid, .cardId, .scheduleValid, .addrSetMode,
		.lockPinOut, .lockPinOe, .beeper, .yellowLed);

	dac_reader_model dac_reader_model_i (
		.sys_clk, .go, .goId, .cardValid, .cardId);

	// Prints the verdict and ends the run.
	task automatic results();
		if (fail_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer, waiting for pready under a bound.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk) penable <= 1;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge sys_clk);
		if (k >= 20) begin
			fail_count++;
			results();
		end
	endtask

	// Checks the one-hot programming state in STATUS.
	task automatic stc(input logic [31:0] e);
		apb(0, OFF_STATUS, 0);
		chk("state", e, 32'(rd[9:5]));
	endtask

	// Presents one card and lets the outputs settle.
	task automatic card(input logic [ID_W-1:0] id);
		go <= 1;
		goId <= id;
		@(posedge sys_clk) go <= 0;
		repeat (4) @(posedge sys_clk);
	endtask

	// Main sequence.
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 0;
		@(posedge sys_clk);
		apb(0, OFF_CTRL, 0);
		chk("ctrl", 32'h000a0007, rd);
		apb(0, 12'h028, 0);
		chk("slverr", 1, 32'(err));
		apb(1, OFF_PINS_LO, 1);
		apb(1, OFF_PINS_HI, 32'h0a);
		apb(1, OFF_PDEL_LO, 2);
		apb(1, OFF_PDEL_HI, 32'h0b);
		addrSetMode <= 1;
		card(IC);
		stc(1);
		addrSetMode <= 0;
		card(IC);
		stc(2);
		chk("yellow", 1, 32'(yellowLed));
		card(CA);
		card(CB);
		card(CC);
		apb(0, OFF_STATUS, 0);
		chk("pointer", 3, 32'(rd[25:16]));
		repeat (16 * TK) @(posedge sys_clk);
		stc(1);
		apb(1, OFF_CTRL, 32'h000a0002);
		card(CA);
		chk("lock", 1, 32'(lockPinOe));
		chk("beep", 1, 32'(beeper));
		chk("pin", 0, 32'(lockPinOut));
		card(IC);
		stc(1);
		repeat (TK) @(posedge sys_clk);
		card(CA);
		repeat (30) @(posedge sys_clk);
		chk("lock", 1, 32'(lockPinOe));
		repeat (2 * TK) @(posedge sys_clk);
		chk("lock", 0, 32'(lockPinOe));
		apb(1, OFF_CMD, 1);
		repeat (3) @(posedge sys_clk);
		chk("lock", 1, 32'(lockPinOe));
		repeat (2 * TK + 5) @(posedge sys_clk);
		apb(1, OFF_CTRL, 32'h000a0202);
		card(CA);
		repeat (2 * TK + 5) @(posedge sys_clk);
		chk("lock", 1, 32'(lockPinOe));
		chk("beep", 0, 32'(beeper));
		card(CA);
		chk("lock", 0, 32'(lockPinOe));
		apb(1, OFF_CTRL, 32'h000a1c02);
		scheduleValid[3] <= 1;
		repeat (3) @(posedge sys_clk);
		chk("lock", 1, 32'(lockPinOe));
		apb(1, OFF_CTRL, 32'h000a1e02);
		repeat (3) @(posedge sys_clk);
		chk("lock", 0, 32'(lockPinOe));
		scheduleValid <= '0;
		apb(1, OFF_CTRL, 32'h000a0100);
		card(CA);
		chk("lock", 1, 32'(lockPinOe));
		apb(1, OFF_CTRL, 32'h001a0002);
		card(CB);
		apb(0, OFF_LAST_LO, 0);
		chk("report", 32'hb6, rd);
		repeat (2 * TK + 5) @(posedge sys_clk);
		apb(1, OFF_CTRL, 32'h00020002);
		card(40'h77000000b6);
		chk("lock", 1, 32'(lockPinOe));
		apb(1, OFF_CTRL, 32'h001a0002);
		repeat (2 * TK + 5) @(posedge sys_clk);
		repeat (6) card(IC);
		stc(8);
		card(CB);
		stc(16);
		card(DC);
		stc(1);
		card(CA);
		chk("lock", 0, 32'(lockPinOe));
		repeat (6) card(DC);
		stc(1);
		apb(0, OFF_STATUS, 0);
		chk("pointer", 0, 32'(rd[25:16]));
		card(CC);
		chk("lock", 0, 32'(lockPinOe));
		apb(0, OFF_EVENTS, 0);
		chk("events", 8, rd);
		results();
	end
endmodule // dac_door_ctrl_bench
